//--- ds3_ovh_consts.svh
// Register offsets, field positions, reset values and timing counts for the DS3 overhead block.
`ifndef DS3_OVH_CONSTS_SVH
`define DS3_OVH_CONSTS_SVH

`define OFF_RX_ALARM_STATUS   6'h00
`define OFF_TX_OVH_CONTROL    6'h01

`define ST_OOF_BIT            6
`define ST_AIS_BIT            5
`define ST_IDLE_BIT           4
`define ST_RX_CKF_BIT         3
`define ST_TX_CKF_BIT         2
`define ST_XBIT_TWO_BIT       1
`define ST_XBIT_ONE_BIT       0

`define CT_AIS_BIT            5
`define CT_IDLE_BIT           4
`define CT_FEBE_BIT           3
`define CT_PBIT_BIT           2
`define CT_CBIT_BIT           1
`define CT_XT_BIT             0
`define CT_RESET              6'h00

`define AIS_METHOD_COUNT      3'h6
`define IDLE_MAX_ERR_GROUPS   3'h5

`define CLK_PERIOD_NS         10
`define CKF_STUCK_NS          1000
`define CKF_STUCK_CYCLES      ((`CKF_STUCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- ds3_ovh_pkg.sv
// Types shared by the DS3 alarm status and transmit overhead control files.
package ds3_ovh_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [2:0] err_req_t;
    typedef logic [2:0] grp_cnt_t;
    typedef logic [7:0] stuck_cnt_t;
endpackage

//--- clock_stuck_monitor.sv
// Detects a monitored clock stuck high or low, seen from the system clock.
`timescale 1ns/1ns
`include "ds3_ovh_consts.svh"

module clock_stuck_monitor (
    // System clock and reset.
    input  wire logic clk,
    input  wire logic reset_n,
    // Monitored clock, sampled as data.
    input  wire logic mon_clk,
    // Failure level.
    output logic      fail
);

    localparam ds3_ovh_pkg::stuck_cnt_t LIMIT = 8'(`CKF_STUCK_CYCLES);

    logic                   s1_q;
    logic                   s2_q;
    logic                   s3_q;
    logic                   edge_seen;
    ds3_ovh_pkg::stuck_cnt_t cnt_q;
    logic                   fail_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= mon_clk;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign edge_seen = s2_q ^ s3_q;

    // Counts system cycles since the last transition, saturating at the limit.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (edge_seen) begin
            cnt_q <= '0;
        end else if (cnt_q != LIMIT) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Raises after the stuck window, clears on the first transition. [R7] [R10]
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fail_q <= 1'b0;
        end else if (edge_seen) begin
            fail_q <= 1'b0;
        end else if (cnt_q == LIMIT - 8'h01) begin
            fail_q <= 1'b1;
        end
    end

    assign fail = fail_q;

    property p_fail_set;
        @(posedge clk) disable iff (!reset_n)
        (cnt_q == LIMIT - 8'h01) && !edge_seen |=> fail_q;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("stuck clock not flagged"); // [R7]

    property p_fail_clear;
        @(posedge clk) disable iff (!reset_n)
        edge_seen |=> !fail_q ##1 (!fail_q || $past(cnt_q) == LIMIT - 8'h01);
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("failure not cleared on edge"); // [R10]

    c_fail_rise: cover property (@(posedge clk) disable iff (!reset_n) $rose(fail_q));

endmodule

//--- rx_idle_xbit_detect.sv
// Receive DS3 idle pattern detector and X-bit capture on the recovered line clock.
`timescale 1ns/1ns
`include "ds3_ovh_consts.svh"

module rx_idle_xbit_detect (
    // Recovered line clock and reset.
    input  wire logic rx_line_clock,
    input  wire logic reset_n,
    // Received bit stream with frame position marks.
    input  wire logic rx_data,
    input  wire logic rx_frame_start,
    input  wire logic rx_overhead_bit,
    input  wire logic rx_x1_slot,
    input  wire logic rx_x2_slot,
    input  wire logic rx_c789_slot,
    // Per-frame results.
    output logic      rx_idle_detected,
    output logic      rx_xbit_one,
    output logic      rx_xbit_two
);

    logic                   phase_q;
    logic [1:0]             pos_q;
    logic                   grp_err_q;
    ds3_ovh_pkg::grp_cnt_t  err_cnt_q;
    logic                   c_zero_q;
    logic                   x1_cap_q;
    logic                   x2_cap_q;
    logic                   idle_q;
    logic                   x1_q;
    logic                   x2_q;
    logic                   bad_bit;
    logic                   grp_bad;

    function automatic ds3_ovh_pkg::grp_cnt_t sat_inc(input ds3_ovh_pkg::grp_cnt_t c);
        sat_inc = (c == 3'h7) ? c : c + 3'h1;
    endfunction

    assign bad_bit = rx_data != ~pos_q[1];
    assign grp_bad = grp_err_q | bad_bit;

    // Tracks the 1100 groups, restarting with 11 after every overhead bit. [R4]
    always_ff @(posedge rx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            pos_q     <= 2'h0;
            grp_err_q <= 1'b0;
            err_cnt_q <= '0;
            phase_q   <= 1'b0;
        end else if (rx_frame_start) begin
            pos_q     <= 2'h0;
            grp_err_q <= 1'b0;
            err_cnt_q <= '0;
            phase_q   <= 1'b1;
        end else if (rx_overhead_bit) begin
            if (pos_q != 2'h0 && grp_err_q) begin
                err_cnt_q <= sat_inc(err_cnt_q);
            end
            pos_q     <= 2'h0;
            grp_err_q <= 1'b0;
        end else if (pos_q == 2'h3) begin
            if (grp_bad) begin
                err_cnt_q <= sat_inc(err_cnt_q);
            end
            pos_q     <= 2'h0;
            grp_err_q <= 1'b0;
        end else begin
            pos_q     <= pos_q + 2'h1;
            grp_err_q <= grp_bad;
        end
    end

    // Watches C7, C8 and C9 of subframe 3 for zeros. [R5]
    always_ff @(posedge rx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            c_zero_q <= 1'b0;
        end else if (rx_frame_start) begin
            c_zero_q <= 1'b1;
        end else if (rx_c789_slot && rx_data) begin
            c_zero_q <= 1'b0;
        end
    end

    always_ff @(posedge rx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            x1_cap_q <= 1'b0;
            x2_cap_q <= 1'b0;
        end else begin
            if (rx_x1_slot) begin
                x1_cap_q <= rx_data;
            end
            if (rx_x2_slot) begin
                x2_cap_q <= rx_data;
            end
        end
    end

    // Judges each completed frame: idle needs at most five errored groups. [R5] [R6]
    always_ff @(posedge rx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            idle_q <= 1'b0;
        end else if (rx_frame_start) begin
            idle_q <= phase_q && c_zero_q && (err_cnt_q <= `IDLE_MAX_ERR_GROUPS);
        end
    end

    // Refreshes the received X-bits once per frame. [R11]
    always_ff @(posedge rx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            x1_q <= 1'b0;
            x2_q <= 1'b0;
        end else if (rx_frame_start) begin
            x1_q <= x1_cap_q;
            x2_q <= x2_cap_q;
        end
    end

    assign rx_idle_detected = idle_q;
    assign rx_xbit_one      = x1_q;
    assign rx_xbit_two      = x2_q;

    property p_idle_exit;
        @(posedge rx_line_clock) disable iff (!reset_n)
        rx_frame_start && err_cnt_q > `IDLE_MAX_ERR_GROUPS |=> !idle_q;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle kept with six errored groups"); // [R6]

    property p_idle_needs_c;
        @(posedge rx_line_clock) disable iff (!reset_n)
        $rose(idle_q) |-> $past(c_zero_q) && $past(rx_frame_start);
    endproperty
    a_idle_needs_c: assert property (p_idle_needs_c) else $error("idle without zero C-bits"); // [R5]

    property p_xbit_refresh;
        @(posedge rx_line_clock) disable iff (!reset_n)
        rx_frame_start |=> x1_q == $past(x1_cap_q) && x2_q == $past(x2_cap_q);
    endproperty
    a_xbit_refresh: assert property (p_xbit_refresh) else $error("X-bits not refreshed"); // [R11]

    c_idle_rise: cover property (@(posedge rx_line_clock) disable iff (!reset_n) $rose(idle_q));

endmodule

//--- ds3_alarm_status_and_tx_overhead_ctrl.sv
// DS3 receive alarm status and transmit overhead control with its register port.
`timescale 1ns/1ns
`include "ds3_ovh_consts.svh"

// Behaviour
// (R1) Receive AIS status comes from one of six detectors picked by a select field.
// (R2) Software checks out-of-frame before trusting a framed AIS indication.
// (R3) Out-of-frame clears only after two consecutive frames of correct F and M patterns.
// (R4) Idle payload expects 1100 groups restarting with 11 after each overhead bit.
// (R5) Idle needs both the payload pattern and zero C7, C8, C9 in subframe 3.
// (R6) Idle judged per frame: five errored groups tolerated, six or more exits.
// (R7) Receive clock stuck 30 to 100 periods flags failure and stops demultiplexing.
// (R8) The receive clock monitor keeps running during line loopback.
// (R9) Software may set tributary AIS control to 11 during line loopback.
// (R10) Stuck transmit clock flags failure and switches transmit to the receive clock.
// (R11) Status bits 1 and 0 show received X2 and X1, refreshed each frame.
// (R12) AIS, idle and clock failure status bits are live, never latched.
// (R13) Transmit AIS control bit requests AIS, with type from a separate field.
// (R14) Software sets idle, X-bit value one and AIS type zero to send idle.
// (R15) A far-end block error request sends exactly one indication next frame.
// (R16) A P-bit error request inverts both P-bits in exactly one frame.
// (R17) A C-bit error request inverts C7, C8, C9 once, only in C-bit mode.
// (R18) Each error request acts once per rising edge of its control bit.
// (R19) The transmit X-bit value goes out on both X1 and X2.
// (R20) Error requests are taken at a transmit frame boundary for a whole frame.
module ds3_alarm_status_and_tx_overhead_ctrl (
    // System clock and reset.
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Register port.
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Configuration from the AIS type-select register.
    input  wire logic [2:0] rx_ais_method_select,
    input  wire logic       tx_ais_type_hi,
    input  wire logic       tx_ais_type_lo,
    // Receive link on the recovered line clock.
    input  wire logic       rx_line_clock,
    input  wire logic       rx_data,
    input  wire logic       rx_frame_start,
    input  wire logic       rx_overhead_bit,
    input  wire logic       rx_x1_slot,
    input  wire logic       rx_x2_slot,
    input  wire logic       rx_c789_slot,
    input  wire logic       rx_frame_pattern_ok,
    input  wire logic       rx_framing_lost,
    input  wire logic [5:0] rx_ais_detect,
    // Transmit link on the selected transmit clock.
    input  wire logic       tx_input_clock,
    input  wire logic       tx_line_clock,
    input  wire logic       tx_frame_start,
    input  wire logic       tx_cbit_mode,
    // System-side controls.
    output logic            rx_demux_enable,
    output logic            tx_clock_use_rx,
    // Transmit overhead controls.
    output logic            tx_ais_send,
    output logic      [1:0] tx_ais_type,
    output logic            tx_idle_send,
    output logic            tx_xbit_value,
    output logic            tx_febe_insert,
    output logic            tx_pbit_invert,
    output logic            tx_cbit_invert
);

    logic                   rx_idle_detected;
    logic                   rx_xbit_one;
    logic                   rx_xbit_two;
    logic                   rx_out_of_frame;
    logic                   oof_q;
    logic                   good_q;
    logic                   rx_clock_fail;
    logic                   tx_clock_fail;
    logic [9:0]             rx_sync1_q;
    logic [9:0]             rx_sync2_q;
    logic                   rx_alarm_indication;
    logic [5:0]             ctrl_q;
    ds3_ovh_pkg::err_req_t  tgl_q;
    ds3_ovh_pkg::err_req_t  rise;
    ds3_ovh_pkg::reg_byte_t status;
    ds3_ovh_pkg::reg_byte_t rdata_q;
    logic [7:0]             tx_sync1_q;
    logic [7:0]             tx_sync2_q;
    ds3_ovh_pkg::err_req_t  tx_tgl_q;
    ds3_ovh_pkg::err_req_t  evt;
    ds3_ovh_pkg::err_req_t  pend_q;
    ds3_ovh_pkg::err_req_t  take;
    ds3_ovh_pkg::err_req_t  ins_q;
    logic [4:0]             tx_lvl_q;

    function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] off);
        reg_hit = (a == off);
    endfunction

    // Receive side: idle pattern and X-bits.
    rx_idle_xbit_detect u_idle (
        .rx_line_clock    (rx_line_clock),
        .reset_n          (reset_n),
        .rx_data          (rx_data),
        .rx_frame_start   (rx_frame_start),
        .rx_overhead_bit  (rx_overhead_bit),
        .rx_x1_slot       (rx_x1_slot),
        .rx_x2_slot       (rx_x2_slot),
        .rx_c789_slot     (rx_c789_slot),
        .rx_idle_detected (rx_idle_detected),
        .rx_xbit_one      (rx_xbit_one),
        .rx_xbit_two      (rx_xbit_two)
    );

    // Out-of-frame clears after two good frames in a row. [R3]
    always_ff @(posedge rx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            oof_q  <= 1'b1;
            good_q <= 1'b0;
        end else if (rx_framing_lost) begin
            oof_q  <= 1'b1;
            good_q <= 1'b0;
        end else if (rx_frame_start) begin
            if (rx_frame_pattern_ok && good_q) begin
                oof_q <= 1'b0;
            end
            good_q <= rx_frame_pattern_ok;
        end
    end

    assign rx_out_of_frame = oof_q;

    // The monitor has no loopback gating, so it keeps watching in loopback. [R8]
    clock_stuck_monitor u_rx_ckmon (
        .clk     (clk),
        .reset_n (reset_n),
        .mon_clk (rx_line_clock),
        .fail    (rx_clock_fail)
    );

    clock_stuck_monitor u_tx_ckmon (
        .clk     (clk),
        .reset_n (reset_n),
        .mon_clk (tx_input_clock),
        .fail    (tx_clock_fail)
    );

    // Receive levels cross into the system domain.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sync1_q <= '0;
            rx_sync2_q <= '0;
        end else begin
            rx_sync1_q <= {rx_ais_detect, rx_out_of_frame, rx_idle_detected,
                           rx_xbit_two, rx_xbit_one};
            rx_sync2_q <= rx_sync1_q;
        end
    end

    // Picks the AIS detector named by the select field. [R1]
    always_comb begin
        rx_alarm_indication = 1'b0;
        if (rx_ais_method_select < `AIS_METHOD_COUNT) begin
            rx_alarm_indication = rx_sync2_q[4'h4 + {1'b0, rx_ais_method_select}];
        end
    end

    // Live status, rebuilt every cycle. [R12] [R11]
    always_comb begin
        status                   = '0;
        status[`ST_OOF_BIT]      = rx_sync2_q[3];
        status[`ST_AIS_BIT]      = rx_alarm_indication;
        status[`ST_IDLE_BIT]     = rx_sync2_q[2];
        status[`ST_RX_CKF_BIT]   = rx_clock_fail;
        status[`ST_TX_CKF_BIT]   = tx_clock_fail;
        status[`ST_XBIT_TWO_BIT] = rx_sync2_q[1];
        status[`ST_XBIT_ONE_BIT] = rx_sync2_q[0];
    end

    // Demultiplexing stops while the receive clock is absent. [R7]
    assign rx_demux_enable = !rx_clock_fail;
    // A failed transmit clock hands over to the receive clock. [R10]
    assign tx_clock_use_rx = tx_clock_fail;

    // Control register and rising-edge toggles for the error requests. [R18]
    assign rise = reg_wdata[`CT_FEBE_BIT:`CT_CBIT_BIT] & ~ctrl_q[`CT_FEBE_BIT:`CT_CBIT_BIT];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `CT_RESET;
            tgl_q  <= '0;
        end else if (reg_write && reg_hit(reg_addr, `OFF_TX_OVH_CONTROL)) begin
            ctrl_q <= reg_wdata[5:0];
            tgl_q  <= tgl_q ^ rise;
        end
    end

    // Read data is registered; unmapped addresses and reserved bits read zero.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (reg_read) begin
            if (reg_hit(reg_addr, `OFF_RX_ALARM_STATUS)) begin
                rdata_q <= status;
            end else if (reg_hit(reg_addr, `OFF_TX_OVH_CONTROL)) begin
                rdata_q <= {2'h0, ctrl_q};
            end else begin
                rdata_q <= '0;
            end
        end
    end

    assign reg_rdata = rdata_q;

    // Control levels and request toggles cross into the transmit domain.
    always_ff @(posedge tx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_sync1_q <= '0;
            tx_sync2_q <= '0;
            tx_tgl_q   <= '0;
        end else begin
            tx_sync1_q <= {tgl_q, ctrl_q[`CT_AIS_BIT], ctrl_q[`CT_IDLE_BIT],
                           ctrl_q[`CT_XT_BIT], tx_ais_type_hi, tx_ais_type_lo};
            tx_sync2_q <= tx_sync1_q;
            tx_tgl_q   <= tx_sync2_q[7:5];
        end
    end

    assign evt  = tx_sync2_q[7:5] ^ tx_tgl_q;
    // C-bit errors wait for a frame in C-bit parity mode. [R17]
    assign take = {tx_frame_start, tx_frame_start, tx_frame_start && tx_cbit_mode};

    // Pending requests; a new request in the take cycle stays pending. [R18] [R20]
    always_ff @(posedge tx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~take) | evt;
        end
    end

    // Insertions are armed at a frame start and last that one frame. [R15] [R16] [R17] [R20]
    always_ff @(posedge tx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            ins_q <= '0;
        end else if (tx_frame_start) begin
            ins_q <= pend_q & take;
        end
    end

    // Steady transmit levels: AIS with its type, idle and X-bit value. [R13] [R19]
    always_ff @(posedge tx_line_clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_lvl_q <= '0;
        end else begin
            tx_lvl_q <= tx_sync2_q[4:0];
        end
    end

    assign tx_febe_insert = ins_q[2];
    assign tx_pbit_invert = ins_q[1];
    assign tx_cbit_invert = ins_q[0];
    assign tx_ais_send    = tx_lvl_q[4];
    assign tx_idle_send   = tx_lvl_q[3];
    assign tx_xbit_value  = tx_lvl_q[2];
    assign tx_ais_type    = tx_lvl_q[1:0];

    property p_oof_clear;
        @(posedge rx_line_clock) disable iff (!reset_n)
        $fell(oof_q) |-> $past(rx_frame_start && rx_frame_pattern_ok && good_q);
    endproperty
    a_oof_clear: assert property (p_oof_clear) else $error("OOF cleared early"); // [R3]

    property p_status_read;
        @(posedge clk) disable iff (!reset_n)
        reg_read && reg_hit(reg_addr, `OFF_RX_ALARM_STATUS) |=>
            reg_rdata == {1'b0, $past(rx_sync2_q[3]), $past(rx_alarm_indication),
                          $past(rx_sync2_q[2]), $past(rx_clock_fail),
                          $past(tx_clock_fail), $past(rx_sync2_q[1:0])};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read mismatch"); // [R12]

    property p_ais_select;
        @(posedge clk) disable iff (!reset_n)
        rx_ais_method_select >= `AIS_METHOD_COUNT |-> !rx_alarm_indication;
    endproperty
    a_ais_select: assert property (p_ais_select) else $error("AIS from unused method"); // [R1]

    property p_no_repeat;
        @(posedge clk) disable iff (!reset_n)
        reg_write && reg_hit(reg_addr, `OFF_TX_OVH_CONTROL) && ctrl_q[`CT_PBIT_BIT]
            |=> tgl_q[1] == $past(tgl_q[1]);
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("request repeated while held"); // [R18]

    property p_ins_at_frame;
        @(posedge tx_line_clock) disable iff (!reset_n)
        $changed(ins_q) |-> $past(tx_frame_start);
    endproperty
    a_ins_at_frame: assert property (p_ins_at_frame) else $error("insertion off frame edge"); // [R20]

    property p_pbit_once;
        @(posedge tx_line_clock) disable iff (!reset_n)
        tx_frame_start && !pend_q[1] |=> !tx_pbit_invert;
    endproperty
    a_pbit_once: assert property (p_pbit_once) else $error("P-bit error repeated"); // [R16]

    property p_cbit_mode;
        @(posedge tx_line_clock) disable iff (!reset_n)
        $rose(tx_cbit_invert) |-> $past(tx_cbit_mode);
    endproperty
    a_cbit_mode: assert property (p_cbit_mode) else $error("C-bit error outside C-bit mode"); // [R17]

    property p_febe_pending;
        @(posedge tx_line_clock) disable iff (!reset_n)
        evt[2] |=> pend_q[2] || tx_febe_insert;
    endproperty
    a_febe_pending: assert property (p_febe_pending) else $error("FEBE request lost"); // [R15]

    c_pbit_insert: cover property (@(posedge tx_line_clock) disable iff (!reset_n)
        $rose(tx_pbit_invert));
    c_oof_clear: cover property (@(posedge rx_line_clock) disable iff (!reset_n) $fell(oof_q));

endmodule

//--- ds3_line_model.sv
// Line interface model sending short idle-style DS3 frames on a gated line clock.
`timescale 1ns/1ns
module ds3_line_model (
    // Controls from the bench.
    input  wire logic       run,
    input  wire logic [2:0] n_err,
    input  wire logic [1:0] xbits,
    // Receive line.
    output logic            rx_line_clock,
    output logic            rx_data,
    output logic            rx_frame_start,
    output logic            rx_overhead_bit,
    output logic            rx_x1_slot,
    output logic            rx_x2_slot,
    output logic            rx_c789_slot
);
    logic [4:0] pos_q = 5'h00;
    logic [4:0] off;
    // The clock stands still while run is low.
    initial begin
        rx_line_clock = 1'b0;
        #1;
        forever #6 rx_line_clock = run ? ~rx_line_clock : rx_line_clock;
    end
    always @(posedge rx_line_clock) pos_q <= pos_q + 5'h01;
    assign off = pos_q - 5'h06;
    assign rx_frame_start = (pos_q == 5'h00);
    assign rx_x1_slot = (pos_q == 5'h01);
    assign rx_x2_slot = (pos_q == 5'h02);
    assign rx_c789_slot = (pos_q >= 5'h03) && (pos_q <= 5'h05);
    assign rx_overhead_bit = (pos_q <= 5'h05);
    // Payload is 1100 restarting after overhead; the first n_err groups are inverted.
    assign rx_data = rx_x1_slot ? xbits[0] : rx_x2_slot ? xbits[1] : rx_overhead_bit ? 1'b0 :
                     ((off[1:0] < 2'h2) ^ (off[4:2] < n_err));
endmodule

//--- tb_ds3_alarm_status_and_tx_overhead_ctrl.sv
// Self-checking bench for the DS3 alarm status and transmit overhead block.
`timescale 1ns/1ns
module tb_ds3_alarm_status_and_tx_overhead_ctrl;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [2:0] sel = 3'h0;
    logic [5:0] ais_det = 6'h00;
    logic run = 1'b1;
    logic tx_run = 1'b1;
    logic [2:0] nerr = 3'h0;
    logic [1:0] xbits = 2'b01;
    logic cmode = 1'b1;
    logic tx_line_clock = 1'b0;
    logic tx_frame_start = 1'b0;
    logic [3:0] fcnt = 4'h0;
    logic rxc, rxd, rfs, rov, rx1, rx2, rc789;
    logic demux, use_rx, ais_s, idle_s, xt, febe, pinv, cinv;
    logic [1:0] ais_t;
    wire [2:0] ins = {febe, pinv, cinv};
    int fail_count = 0, n_tests = 0;
    initial forever #5 clk = ~clk;
    initial begin
        #3;
        forever #6 tx_line_clock = ~tx_line_clock;
    end
    always @(posedge tx_line_clock) begin
        fcnt <= fcnt + 4'h1;
        tx_frame_start <= (fcnt == 4'hf);
    end
    ds3_line_model ds3_line_model_i (.run(run), .n_err(nerr), .xbits(xbits),
        .rx_line_clock(rxc), .rx_data(rxd), .rx_frame_start(rfs), .rx_overhead_bit(rov),
        .rx_x1_slot(rx1), .rx_x2_slot(rx2), .rx_c789_slot(rc789));
    ds3_alarm_status_and_tx_overhead_ctrl ds3_alarm_status_and_tx_overhead_ctrl_i (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_ais_method_select(sel), .tx_ais_type_hi(sel[1]), .tx_ais_type_lo(sel[0]),
        .rx_line_clock(rxc), .rx_data(rxd), .rx_frame_start(rfs), .rx_overhead_bit(rov),
        .rx_x1_slot(rx1), .rx_x2_slot(rx2), .rx_c789_slot(rc789),
        .rx_frame_pattern_ok(rfs), .rx_framing_lost(nerr == 3'h6), .rx_ais_detect(ais_det),
        .tx_input_clock(tx_line_clock & tx_run), .tx_line_clock(tx_line_clock),
        .tx_frame_start(tx_frame_start), .tx_cbit_mode(cmode), .rx_demux_enable(demux),
        .tx_clock_use_rx(use_rx), .tx_ais_send(ais_s), .tx_ais_type(ais_t),
        .tx_idle_send(idle_s), .tx_xbit_value(xt), .tx_febe_insert(febe),
        .tx_pbit_invert(pinv), .tx_cbit_invert(cinv));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & m, e);
    endtask
    task automatic t_regs;
        rc(6'h01, 8'hff, 8'h00);
        rc(6'h3f, 8'hff, 8'h00);
        rc(6'h00, 8'hc0, 8'h40);
        wr(6'h01, 8'hd1);
        wr(6'h00, 8'hff);
        rc(6'h01, 8'hff, 8'h11);
        repeat (10) @(negedge tx_line_clock);
        chk({3'h0, ais_s, idle_s, xt, ais_t}, 8'h0c);
        wr(6'h01, 8'h20);
        repeat (10) @(negedge tx_line_clock);
        chk({3'h0, ais_s, idle_s, xt, ais_t}, 8'h10);
    endtask
    task automatic t_ais;
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            {sel, ais_det} <= {3'(m), 6'h01 << m};
            repeat (10) @(posedge clk);
            rc(6'h00, 8'h20, {2'h0, m < 6, 5'h00});
            chk({6'h00, ais_t}, {6'h00, 2'(m)});
            @(posedge clk) ais_det <= ~(6'h01 << m);
            repeat (10) @(posedge clk);
            rc(6'h00, 8'h20, 8'h00);
        end
    endtask
    task automatic t_idle;
        repeat (200) @(posedge clk);
        rc(6'h00, 8'h7f, 8'h11);
        @(posedge clk) nerr <= 3'h5;
        repeat (200) @(posedge clk);
        rc(6'h00, 8'h7f, 8'h11);
        @(posedge clk) {nerr, xbits} <= {3'h6, 2'b10};
        repeat (200) @(posedge clk);
        rc(6'h00, 8'h7f, 8'h42);
    endtask
    task automatic t_err;
        int n;
        @(posedge tx_line_clock) cmode <= 1'b0;
        for (int i = 1; i < 4; i++) begin
            wr(6'h01, 8'h01 << i);
            if (i == 1) begin
                repeat (40) @(negedge tx_line_clock);
                chk({5'h00, ins}, 8'h00);
                @(posedge tx_line_clock) cmode <= 1'b1;
            end
            n = 0;
            while (ins[i-1] !== 1'b1 && n < 100) begin
                @(negedge tx_line_clock);
                n++;
            end
            n = 0;
            while (ins[i-1] === 1'b1 && n < 40) begin
                @(negedge tx_line_clock);
                n++;
            end
            chk(8'(n), 8'h10);
            wr(6'h01, 8'h01 << i);
            repeat (40) @(negedge tx_line_clock);
            chk({5'h00, ins}, 8'h00);
            wr(6'h01, 8'h00);
        end
    endtask
    task automatic t_ckf;
        {run, tx_run} <= 2'b00;
        repeat (130) @(posedge clk);
        rc(6'h00, 8'h0c, 8'h0c);
        chk({6'h00, demux, use_rx}, 8'h01);
        @(posedge clk) {run, tx_run} <= 2'b11;
        repeat (10) @(posedge clk);
        rc(6'h00, 8'h0c, 8'h00);
        chk({6'h00, demux, use_rx}, 8'h02);
    endtask
    task automatic stop_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_regs;
        t_ais;
        t_idle;
        t_err;
        t_ckf;
        stop_test;
    end
endmodule
